// >>> include/sch_map.svh
// Frame codes, settings indexes, reset values and register offsets
`ifndef SCH_MAP_SVH
`define SCH_MAP_SVH
`define SCH_SOF 8'h02
`define SCH_CMD_READ_REQ 8'h10
`define SCH_CMD_WRITE_REQ 8'h11
`define SCH_CNF_OFFSET 8'h40
`define SCH_CMD_READ_CNF 8'h50
`define SCH_CMD_WRITE_CNF 8'h51
`define SCH_ST_OK 8'h00
`define SCH_ST_FAIL 8'h01
`define SCH_IDX_SECURITY 8'h0C
`define SCH_IDX_SCAN 8'h0D
`define SCH_IDX_PERIPH_SEC 8'h2C
`define SCH_RST_SECURITY 8'h00
`define SCH_RST_SCAN 8'h00
`define SCH_RST_PERIPH_SEC 8'h0B
`define SCH_SEC_METHOD_MSB 2
`define SCH_SEC_BOND_BIT 3
`define SCH_METHOD_STATIC 3'h3
`define SCH_METHOD_LESC_NUM 3'h4
`define SCH_METHOD_LESC_KEY 3'h5
`define SCH_SCAN_ACTIVE_BIT 0
`define SCH_BEACON_RAW 8'h02
`define SCH_BOND_MAX_PEERS 6'h20
`define SCH_HDR_BYTES 16'h0004
`define SCH_OFF_CMD 32'h0000_0000
`define SCH_OFF_ARG 32'h0000_0004
`define SCH_OFF_STATUS 32'h0000_0008
`endif

// >>> include/sch_pkg.sv
// Types shared by both ends of the settings link
package sch_pkg;
   typedef logic [7:0] sch_byte_t;
   typedef enum logic [2:0] {
      SCH_RX_START = 3'h0,
      SCH_RX_CMD = 3'h1,
      SCH_RX_LEN_LO = 3'h3,
      SCH_RX_LEN_HI = 3'h2,
      SCH_RX_PAYLOAD = 3'h6,
      SCH_RX_CHECK = 3'h7
   } sch_rx_state_t;
endpackage

// >>> include/sch_link_if.sv
// Byte link between the settings host and the device
`timescale 1ns/10ps
`default_nettype none
interface sch_link_if;
   logic [7:0] h2d_data;
   logic h2d_valid;
   logic h2d_ready;
   logic [7:0] d2h_data;
   logic d2h_valid;
   logic d2h_ready;
   modport dev (input h2d_data, input h2d_valid, output h2d_ready,
      output d2h_data, output d2h_valid, input d2h_ready);
   modport host (output h2d_data, output h2d_valid, input h2d_ready,
      input d2h_data, input d2h_valid, output d2h_ready);
endinterface
`default_nettype wire

// >>> core/sch_device.sv
// Settings command handler, device end
//
// Overview of operation
// - Frames: 0x02, command, length LSB first, payload, check
// - Host writes settings with request 0x11
// - Write confirm 0x51, length one, status 0x00, or 0x01 on refusal
// - Host reads settings with request 0x10, length one
// - Read confirm 0x50: status then one value byte, no value byte on refusal
// - Security setting at index 0x0C, 0x0B static+bond
// - Peripheral-only security at index 44, default 11
// - Peripheral-only rejects elliptic-curve key methods
// - Scan setting index 13, default 0, bit0 only
// - Host sums chosen scan bits into one value
// - Scan bit0 makes started scans active
// - Beacons force active scan, except raw beacon output
// - Security bits 2:0 pick method, 0x3 static key
// - Security bit3 enables bonding, up to 32 peers
`timescale 1ns/10ps
`default_nettype none
`include "sch_map.svh"
module sch_device (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Link
   sch_link_if.dev link,
   // Radio side
   input wire logic scan_begin_request,
   input wire logic adv_received,
   input wire logic [7:0] beacon_receive_config,
   input wire logic bond_add,
   output logic [2:0] pairing_method,
   output logic bond_store_enable,
   output logic [2:0] periph_pairing_method,
   output logic periph_bond_enable,
   output logic scan_running,
   output logic scan_request,
   output logic [5:0] bond_count
);
   import sch_pkg::*;

   // Method legal for the mode; reserved codes refused
   function automatic logic method_ok(input sch_byte_t v, input logic periph);
      method_ok = (v[`SCH_SEC_METHOD_MSB:0] <= `SCH_METHOD_LESC_KEY) &&
         !(periph && (v[`SCH_SEC_METHOD_MSB:0] == `SCH_METHOD_LESC_NUM ||
         v[`SCH_SEC_METHOD_MSB:0] == `SCH_METHOD_LESC_KEY));
   endfunction

   sch_rx_state_t rx_state_reg;
   sch_byte_t rx_cmd_reg;
   sch_byte_t rx_idx_reg;
   sch_byte_t rx_val_reg;
   sch_byte_t rx_chk_reg;
   logic [15:0] rx_len_reg;
   logic [15:0] rx_cnt_reg;
   logic rx_ready_reg;
   logic exec_reg;
   sch_byte_t security_config_reg;
   sch_byte_t scan_behaviour_reg;
   sch_byte_t periph_only_security_reg;
   sch_byte_t tx_cmd_reg;
   sch_byte_t tx_status_reg;
   sch_byte_t tx_val_reg;
   sch_byte_t tx_data_reg;
   sch_byte_t tx_chk_reg;
   logic [15:0] tx_len_reg;
   logic [15:0] tx_pos_reg;
   logic tx_valid_reg;
   logic scan_active_mode_reg;
   logic scan_running_reg;
   logic scan_request_reg;
   logic [5:0] bond_count_reg;
   logic rx_fire;
   logic tx_fire;
   logic len_ok;
   logic idx_ok;
   logic wr_ok;
   sch_byte_t rd_val;
   sch_byte_t resp_status;
   logic [15:0] tx_pos_next;
   logic active_scan;

   assign rx_fire = link.h2d_valid && rx_ready_reg;
   assign tx_fire = tx_valid_reg && link.d2h_ready;
   assign link.h2d_ready = rx_ready_reg;
   assign link.d2h_data = tx_data_reg;
   assign link.d2h_valid = tx_valid_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_state_reg <= SCH_RX_START;
         rx_cmd_reg <= 8'h00;
         rx_idx_reg <= 8'h00;
         rx_val_reg <= 8'h00;
         rx_chk_reg <= 8'h00;
         rx_len_reg <= 16'h0000;
         rx_cnt_reg <= 16'h0000;
         exec_reg <= 1'b0;
      end else begin
         exec_reg <= 1'b0;
         if (rx_fire) begin
            rx_chk_reg <= rx_chk_reg ^ link.h2d_data;
            case (rx_state_reg)
               SCH_RX_START: begin
                  rx_chk_reg <= link.h2d_data;
                  if (link.h2d_data == `SCH_SOF) begin
                     rx_state_reg <= SCH_RX_CMD;
                  end
               end
               SCH_RX_CMD: begin
                  rx_cmd_reg <= link.h2d_data;
                  rx_state_reg <= SCH_RX_LEN_LO;
               end
               SCH_RX_LEN_LO: begin
                  rx_len_reg[7:0] <= link.h2d_data;
                  rx_state_reg <= SCH_RX_LEN_HI;
               end
               SCH_RX_LEN_HI: begin
                  rx_len_reg[15:8] <= link.h2d_data;
                  rx_cnt_reg <= 16'h0000;
                  if ({link.h2d_data, rx_len_reg[7:0]} == 16'h0000) begin
                     rx_state_reg <= SCH_RX_CHECK;
                  end else begin
                     rx_state_reg <= SCH_RX_PAYLOAD;
                  end
               end
               SCH_RX_PAYLOAD: begin
                  if (rx_cnt_reg == 16'h0000) begin
                     rx_idx_reg <= link.h2d_data;
                  end
                  if (rx_cnt_reg == 16'h0001) begin
                     rx_val_reg <= link.h2d_data;
                  end
                  rx_cnt_reg <= rx_cnt_reg + 16'h0001;
                  if (rx_cnt_reg + 16'h0001 == rx_len_reg) begin
                     rx_state_reg <= SCH_RX_CHECK;
                  end
               end
               SCH_RX_CHECK: begin
                  rx_state_reg <= SCH_RX_START;
                  exec_reg <= (rx_chk_reg == link.h2d_data) &&
                     (rx_cmd_reg == `SCH_CMD_WRITE_REQ ||
                     rx_cmd_reg == `SCH_CMD_READ_REQ);
               end
               default: rx_state_reg <= SCH_RX_START;
            endcase
         end
      end
   end

   // Command decode for the frame just checked
   always_comb begin
      idx_ok = (rx_idx_reg == `SCH_IDX_SECURITY) || (rx_idx_reg == `SCH_IDX_SCAN) ||
         (rx_idx_reg == `SCH_IDX_PERIPH_SEC);
      len_ok = (rx_cmd_reg == `SCH_CMD_WRITE_REQ) ? (rx_len_reg == 16'h0002) :
         (rx_len_reg == 16'h0001);
      wr_ok = 1'b1;
      rd_val = 8'h00;
      case (rx_idx_reg)
         `SCH_IDX_SECURITY: begin
            rd_val = security_config_reg;
            wr_ok = method_ok(rx_val_reg, 1'b0);
         end
         `SCH_IDX_PERIPH_SEC: begin
            rd_val = periph_only_security_reg;
            wr_ok = method_ok(rx_val_reg, 1'b1);
         end
         `SCH_IDX_SCAN: rd_val = scan_behaviour_reg;
         default: rd_val = 8'h00;
      endcase
      if (rx_cmd_reg == `SCH_CMD_WRITE_REQ) begin
         resp_status = (len_ok && idx_ok && wr_ok) ? `SCH_ST_OK : `SCH_ST_FAIL;
      end else begin
         resp_status = (len_ok && idx_ok) ? `SCH_ST_OK : `SCH_ST_FAIL;
      end
   end

   // Settings storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         security_config_reg <= `SCH_RST_SECURITY;
         scan_behaviour_reg <= `SCH_RST_SCAN;
         periph_only_security_reg <= `SCH_RST_PERIPH_SEC;
      end else if (exec_reg && rx_cmd_reg == `SCH_CMD_WRITE_REQ &&
         resp_status == `SCH_ST_OK) begin
         case (rx_idx_reg)
            `SCH_IDX_SECURITY: security_config_reg <= rx_val_reg;
            `SCH_IDX_PERIPH_SEC: periph_only_security_reg <= rx_val_reg;
            `SCH_IDX_SCAN: scan_behaviour_reg <= {7'h00, rx_val_reg[`SCH_SCAN_ACTIVE_BIT]};
            default: security_config_reg <= security_config_reg;
         endcase
      end
   end

   // Confirmation sender; intake stalls until the answer is out
   always_comb begin
      tx_pos_next = tx_pos_reg + 16'h0001;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_cmd_reg <= 8'h00;
         tx_status_reg <= 8'h00;
         tx_val_reg <= 8'h00;
         tx_data_reg <= 8'h00;
         tx_chk_reg <= 8'h00;
         tx_len_reg <= 16'h0000;
         tx_pos_reg <= 16'h0000;
         tx_valid_reg <= 1'b0;
         rx_ready_reg <= 1'b1;
      end else if (rx_fire && rx_state_reg == SCH_RX_CHECK) begin
         rx_ready_reg <= 1'b0;
      end else if (exec_reg) begin
         tx_cmd_reg <= rx_cmd_reg + `SCH_CNF_OFFSET;
         tx_status_reg <= resp_status;
         tx_val_reg <= rd_val;
         tx_len_reg <= (rx_cmd_reg == `SCH_CMD_READ_REQ && resp_status == `SCH_ST_OK) ?
            16'h0002 : 16'h0001;
         tx_pos_reg <= 16'h0000;
         tx_data_reg <= `SCH_SOF;
         tx_valid_reg <= 1'b1;
      end else if (tx_fire) begin
         tx_pos_reg <= tx_pos_next;
         tx_chk_reg <= (tx_pos_reg == 16'h0000) ? tx_data_reg : tx_chk_reg ^ tx_data_reg;
         if (tx_pos_reg == `SCH_HDR_BYTES + tx_len_reg) begin
            tx_valid_reg <= 1'b0;
            rx_ready_reg <= 1'b1;
         end else if (tx_pos_next == `SCH_HDR_BYTES + tx_len_reg) begin
            tx_data_reg <= tx_chk_reg ^ tx_data_reg;
         end else begin
            case (tx_pos_next)
               16'h0001: tx_data_reg <= tx_cmd_reg;
               16'h0002: tx_data_reg <= tx_len_reg[7:0];
               16'h0003: tx_data_reg <= tx_len_reg[15:8];
               16'h0004: tx_data_reg <= tx_status_reg;
               default: tx_data_reg <= tx_val_reg;
            endcase
         end
      end else if (!tx_valid_reg && !exec_reg && rx_state_reg != SCH_RX_CHECK) begin
         rx_ready_reg <= 1'b1;
      end
   end

   // Beacons force active, raw output excepted
   assign active_scan = scan_behaviour_reg[`SCH_SCAN_ACTIVE_BIT] ||
      (beacon_receive_config != 8'h00 && beacon_receive_config != `SCH_BEACON_RAW);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_running_reg <= 1'b0;
         scan_active_mode_reg <= 1'b0;
         scan_request_reg <= 1'b0;
      end else begin
         if (scan_begin_request) begin
            scan_running_reg <= 1'b1;
            scan_active_mode_reg <= active_scan;
         end
         scan_request_reg <= scan_running_reg && scan_active_mode_reg && adv_received;
      end
   end

   // Bond table fills to 32 peers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bond_count_reg <= 6'h00;
      end else if (bond_add && security_config_reg[`SCH_SEC_BOND_BIT] &&
         bond_count_reg != `SCH_BOND_MAX_PEERS) begin
         bond_count_reg <= bond_count_reg + 6'h01;
      end
   end

   assign pairing_method = security_config_reg[`SCH_SEC_METHOD_MSB:0];
   assign bond_store_enable = security_config_reg[`SCH_SEC_BOND_BIT];
   assign periph_pairing_method = periph_only_security_reg[`SCH_SEC_METHOD_MSB:0];
   assign periph_bond_enable = periph_only_security_reg[`SCH_SEC_BOND_BIT];
   assign scan_running = scan_running_reg;
   assign scan_request = scan_request_reg;
   assign bond_count = bond_count_reg;
endmodule // sch_device
`default_nettype wire

// >>> core/sch_host.sv
// Settings command handler, host end with AHB-Lite command registers
`timescale 1ns/10ps
`default_nettype none
`include "sch_map.svh"
module sch_host (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Link
   sch_link_if.host link
);
   import sch_pkg::*;

   sch_rx_state_t rx_state_reg;
   sch_byte_t rx_cmd_reg;
   sch_byte_t rx_status_reg;
   sch_byte_t rx_val_reg;
   sch_byte_t rx_chk_reg;
   logic [15:0] rx_len_reg;
   logic [15:0] rx_cnt_reg;
   logic rx_end;
   logic rx_bad;
   sch_byte_t arg_index_reg;
   sch_byte_t arg_value_reg;
   logic busy_reg;
   logic done_reg;
   logic chk_err_reg;
   logic wr_pend_reg;
   logic [31:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   sch_byte_t tx_data_reg;
   sch_byte_t tx_chk_reg;
   sch_byte_t tx_cmd_reg;
   logic [15:0] tx_len_reg;
   logic [15:0] tx_pos_reg;
   logic [15:0] tx_pos_next;
   logic tx_valid_reg;
   logic start;
   logic [31:0] status_word;
   logic tx_fire;

   assign status_word = {rx_cmd_reg, rx_val_reg, rx_status_reg, 5'h00, chk_err_reg,
      done_reg, busy_reg};
   assign start = wr_pend_reg && wr_addr_reg == `SCH_OFF_CMD && hwdata[0] && !busy_reg;
   assign tx_fire = tx_valid_reg && link.h2d_ready;
   assign tx_pos_next = tx_pos_reg + 16'h0001;
   assign rx_end = link.d2h_valid && rx_state_reg == SCH_RX_CHECK;
   assign rx_bad = rx_chk_reg != link.d2h_data;
   assign link.h2d_data = tx_data_reg;
   assign link.h2d_valid = tx_valid_reg;
   assign link.d2h_ready = 1'b1;
   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Bus slave: zero wait, read data registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h0000_0000;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
         wr_addr_reg <= haddr;
         if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr)
               `SCH_OFF_ARG: hrdata_reg <= {16'h0000, arg_value_reg, arg_index_reg};
               `SCH_OFF_STATUS: hrdata_reg <= status_word;
               default: hrdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         arg_index_reg <= 8'h00;
         arg_value_reg <= 8'h00;
      end else if (wr_pend_reg && wr_addr_reg == `SCH_OFF_ARG && !busy_reg) begin
         arg_index_reg <= hwdata[7:0];
         arg_value_reg <= hwdata[15:8];
      end
   end

   // Done is cleared by a command write; an answer in that cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         chk_err_reg <= 1'b0;
      end else if (rx_end) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b1;
         chk_err_reg <= rx_bad;
      end else if (start) begin
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
         chk_err_reg <= 1'b0;
      end
   end

   // Request sender
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_data_reg <= 8'h00;
         tx_chk_reg <= 8'h00;
         tx_cmd_reg <= 8'h00;
         tx_len_reg <= 16'h0000;
         tx_pos_reg <= 16'h0000;
         tx_valid_reg <= 1'b0;
      end else if (start) begin
         // Write carries index and value, read only index
         tx_cmd_reg <= hwdata[1] ? `SCH_CMD_WRITE_REQ : `SCH_CMD_READ_REQ;
         tx_len_reg <= hwdata[1] ? 16'h0002 : 16'h0001;
         tx_pos_reg <= 16'h0000;
         tx_data_reg <= `SCH_SOF;
         tx_valid_reg <= 1'b1;
      end else if (tx_fire) begin
         tx_pos_reg <= tx_pos_next;
         tx_chk_reg <= (tx_pos_reg == 16'h0000) ? tx_data_reg : tx_chk_reg ^ tx_data_reg;
         if (tx_pos_reg == `SCH_HDR_BYTES + tx_len_reg) begin
            tx_valid_reg <= 1'b0;
         end else if (tx_pos_next == `SCH_HDR_BYTES + tx_len_reg) begin
            tx_data_reg <= tx_chk_reg ^ tx_data_reg;
         end else begin
            case (tx_pos_next)
               16'h0001: tx_data_reg <= tx_cmd_reg;
               16'h0002: tx_data_reg <= tx_len_reg[7:0];
               16'h0003: tx_data_reg <= tx_len_reg[15:8];
               16'h0004: tx_data_reg <= arg_index_reg;
               // Value written as given, bits already summed
               default: tx_data_reg <= arg_value_reg;
            endcase
         end
      end
   end

   // Confirmation parser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_state_reg <= SCH_RX_START;
         rx_cmd_reg <= 8'h00;
         rx_status_reg <= 8'h00;
         rx_val_reg <= 8'h00;
         rx_chk_reg <= 8'h00;
         rx_len_reg <= 16'h0000;
         rx_cnt_reg <= 16'h0000;
      end else if (link.d2h_valid) begin
         rx_chk_reg <= rx_chk_reg ^ link.d2h_data;
         case (rx_state_reg)
            SCH_RX_START: begin
               rx_chk_reg <= link.d2h_data;
               if (link.d2h_data == `SCH_SOF) begin
                  rx_state_reg <= SCH_RX_CMD;
               end
            end
            SCH_RX_CMD: begin
               rx_cmd_reg <= link.d2h_data;
               rx_val_reg <= 8'h00;
               rx_state_reg <= SCH_RX_LEN_LO;
            end
            SCH_RX_LEN_LO: begin
               rx_len_reg[7:0] <= link.d2h_data;
               rx_state_reg <= SCH_RX_LEN_HI;
            end
            SCH_RX_LEN_HI: begin
               rx_len_reg[15:8] <= link.d2h_data;
               rx_cnt_reg <= 16'h0000;
               if ({link.d2h_data, rx_len_reg[7:0]} == 16'h0000) begin
                  rx_state_reg <= SCH_RX_CHECK;
               end else begin
                  rx_state_reg <= SCH_RX_PAYLOAD;
               end
            end
            SCH_RX_PAYLOAD: begin
               if (rx_cnt_reg == 16'h0000) begin
                  rx_status_reg <= link.d2h_data;
               end
               if (rx_cnt_reg == 16'h0001) begin
                  rx_val_reg <= link.d2h_data;
               end
               rx_cnt_reg <= rx_cnt_reg + 16'h0001;
               if (rx_cnt_reg + 16'h0001 == rx_len_reg) begin
                  rx_state_reg <= SCH_RX_CHECK;
               end
            end
            SCH_RX_CHECK: rx_state_reg <= SCH_RX_START;
            default: rx_state_reg <= SCH_RX_START;
         endcase
      end
   end
endmodule // sch_host
`default_nettype wire

// >>> verification/sch_link_sva.sv
// Framing checker for the settings byte link
`timescale 1ns/10ps
`default_nettype none
module sch_link_sva (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Link
   input wire logic [7:0] h2d_data,
   input wire logic h2d_valid,
   input wire logic h2d_ready,
   input wire logic [7:0] d2h_data,
   input wire logic d2h_valid,
   input wire logic d2h_ready
);
   logic [15:0] di, dl, hi, hl;
   logic [7:0] dx, dc;
   logic dt, ht, dlast, hlast;
   assign dt = d2h_valid && d2h_ready;
   assign ht = h2d_valid && h2d_ready;
   assign dlast = di > 16'h0003 && di == dl + 16'h0004;
   assign hlast = hi > 16'h0003 && hi == hl + 16'h0004;
   // Answer byte position, length, command and running XOR
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         di <= 16'h0000;
         dl <= 16'h0000;
         dx <= 8'h00;
         dc <= 8'h00;
      end else if (dt) begin
         di <= dlast ? 16'h0000 : di + 16'h0001;
         dx <= (di == 16'h0000) ? d2h_data : dx ^ d2h_data;
         if (di == 16'h0001) dc <= d2h_data;
         if (di == 16'h0002) dl[7:0] <= d2h_data;
         if (di == 16'h0003) dl[15:8] <= d2h_data;
      end
   end
   // Request byte position and length
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi <= 16'h0000;
         hl <= 16'h0000;
      end else if (ht) begin
         hi <= hlast ? 16'h0000 : hi + 16'h0001;
         if (hi == 16'h0002) hl[7:0] <= h2d_data;
         if (hi == 16'h0003) hl[15:8] <= h2d_data;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence chk_taken;
      ht && hlast;
   endsequence
   sequence ans_start;
      d2h_valid && di == 16'h0000 && d2h_data == 8'h02;
   endsequence
   ans_sof_a: assert property (d2h_valid && di == 16'h0000 |-> d2h_data == 8'h02)
      else $error("answer frame does not open with start byte");
   req_sof_a: assert property (h2d_valid && hi == 16'h0000 |-> h2d_data == 8'h02)
      else $error("request frame does not open with start byte");
   cnf_code_a: assert property (d2h_valid && di == 16'h0001 |-> d2h_data inside {8'h50, 8'h51})
      else $error("answer code is not a confirm code");
   wr_len_a: assert property (d2h_valid && di == 16'h0002 && dc == 8'h51 |-> d2h_data == 8'h01)
      else $error("write confirm length is not one");
   len_hi_a: assert property (d2h_valid && di == 16'h0003 |-> d2h_data == 8'h00)
      else $error("answer length high byte not zero");
   check_byte_a: assert property (d2h_valid && dlast |-> d2h_data == dx)
      else $error("answer check byte wrong");
   busy_hold_a: assert property (d2h_valid |-> !h2d_ready)
      else $error("device takes bytes while answering");
   ans_delay_a: assert property (chk_taken |=> !h2d_ready ##[0:2] ans_start)
      else $error("answer does not follow the check byte in time");
   read_ok_a: assert property (d2h_valid && di == 16'h0001 && d2h_data == 8'h50 |=> ##[0:4] (d2h_valid && di == 16'h0002 && d2h_data inside {8'h01, 8'h02}))
      else $error("read confirm length wrong");
endmodule // sch_link_sva
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench joining host and device ends of the settings link
`timescale 1ns/10ps
`default_nettype none
`include "sch_map.svh"
module testbench;
   logic hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, pairing_method, periph_pairing_method;
   logic scan_begin_request, adv_received, bond_add, bond_store_enable;
   logic periph_bond_enable, scan_running, scan_request, seen;
   logic [7:0] beacon_receive_config, rv;
   logic [5:0] bond_count;
   logic [63:0] nq[$];
   logic [63:0] got;
   int errors, tests_run, gi, cyc;
   always #4 hclk = ~hclk;
   sch_link_if lk();
   sch_device sch_device_inst (.hclk, .hresetn, .link(lk), .scan_begin_request, .adv_received,
      .beacon_receive_config, .bond_add, .pairing_method, .bond_store_enable,
      .periph_pairing_method, .periph_bond_enable, .scan_running, .scan_request, .bond_count);
   sch_host sch_host_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .link(lk));
   sch_link_sva sch_link_sva_inst (.hclk, .hresetn, .h2d_data(lk.h2d_data),
      .h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data),
      .d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));
   task close_out;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string n, input logic [63:0] e, g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   function logic [63:0] frm(input logic [7:0] c, st, v, input logic two);
      logic [63:0] f;
      logic [7:0] ck;
      f = {16'h0000, v, st, 8'h00, two ? 8'h02 : 8'h01, c, `SCH_SOF};
      if (!two) f[47:40] = 8'h00;
      ck = 8'h00;
      for (int i = 0; i < 5 + two; i++) ck ^= f[i*8+:8];
      f[(5+two)*8+:8] = ck;
      return f;
   endfunction
   // Whole answer frames off the wire against the oldest note
   always @(posedge hclk) begin
      if (hresetn && lk.d2h_valid && lk.d2h_ready) begin
         got[gi*8+:8] = lk.d2h_data;
         gi++;
         if (gi > 5 && gi == 5 + got[23:16]) begin
            if (nq.size() == 0) chk("unexpected answer", 64'h0, got);
            else chk("answer frame", nq.pop_front(), got);
            got = 64'h0;
            gi = 0;
         end
      end
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         errors++;
         close_out;
      end
   end
   task ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task cmd(input logic w, input logic [7:0] ix, v, st, ev);
      logic [31:0] r;
      int k;
      nq.push_back(frm(w ? `SCH_CMD_WRITE_CNF : `SCH_CMD_READ_CNF, st, ev, !w && st == 8'h00));
      ahb(1'b1, `SCH_OFF_ARG, {16'h0000, v, ix}, r);
      ahb(1'b0, `SCH_OFF_ARG, 32'h0, r);
      chk("argument", {16'h0000, v, ix}, r);
      ahb(1'b1, `SCH_OFF_CMD, {30'h0, w, 1'b1}, r);
      k = 0;
      do begin
         ahb(1'b0, `SCH_OFF_STATUS, 32'h0, r);
         k++;
      end while (r[1:0] !== 2'b10 && k < 100);
      chk("status", {w ? 8'h51 : 8'h50, ev, st, 3'h2}, {r[31:8], r[2:0]});
   endtask
   task scan_try(input logic exp);
      @(posedge hclk) scan_begin_request <= 1'b1;
      @(posedge hclk) scan_begin_request <= 1'b0;
      @(posedge hclk) adv_received <= 1'b1;
      @(posedge hclk) adv_received <= 1'b0;
      seen = 1'b0;
      repeat (4) @(posedge hclk) seen |= scan_request;
      chk("scan request", exp, seen);
      chk("scan running", 1'b1, scan_running);
   endtask
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, hsize} = {4'h0, 64'h0, 3'h2};
      {scan_begin_request, adv_received, bond_add, beacon_receive_config} = 11'h0;
      {errors, tests_run, gi, cyc, got} = '0;
      rv = 8'($urandom(32'hDD7B0282));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk("periph fields", 4'h7, {periph_pairing_method, periph_bond_enable});
      cmd(1'b0, 8'h0C, 8'h00, 8'h00, `SCH_RST_SECURITY);
      cmd(1'b0, 8'h2C, 8'h00, 8'h00, 8'h0B);
      cmd(1'b0, 8'h0D, 8'h00, 8'h00, 8'h00);
      $display("reset values test done");
      cmd(1'b1, 8'h0C, 8'h0B, 8'h00, 8'h00);
      cmd(1'b0, 8'h0C, 8'h00, 8'h00, 8'h0B);
      chk("security fields", 4'h7, {pairing_method, bond_store_enable});
      $display("security write test done");
      for (int m = 4; m < 8; m++) cmd(1'b1, 8'h2C, 8'(m), 8'h01, 8'h00);
      rv = 8'($urandom_range(3)) | (8'($urandom_range(1)) << 3);
      cmd(1'b1, 8'h2C, rv, 8'h00, 8'h00);
      cmd(1'b0, 8'h2C, 8'h00, 8'h00, rv);
      chk("periph fields", {rv[2:0], rv[3]}, {periph_pairing_method, periph_bond_enable});
      cmd(1'b0, 8'h0E, 8'h00, 8'h01, 8'h00);
      cmd(1'b1, 8'h0E, 8'h01, 8'h01, 8'h00);
      $display("peripheral and refusal test done");
      beacon_receive_config <= `SCH_BEACON_RAW;
      scan_try(1'b0);
      cmd(1'b1, 8'h0D, 8'h03, 8'h00, 8'h00);
      cmd(1'b0, 8'h0D, 8'h00, 8'h00, 8'h01);
      scan_try(1'b1);
      cmd(1'b1, 8'h0D, 8'h00, 8'h00, 8'h00);
      beacon_receive_config <= 8'h01;
      scan_try(1'b1);
      $display("scan test done");
      repeat (40) begin
         @(posedge hclk) bond_add <= 1'b1;
         @(posedge hclk) bond_add <= 1'b0;
      end
      @(posedge hclk);
      chk("bond count", `SCH_BOND_MAX_PEERS, bond_count);
      $display("bond count test done");
      repeat (10) @(posedge hclk);
      chk("bus response", 2'b10, {hreadyout, hresp});
      chk("notes left", 0, nq.size());
      close_out;
   end
endmodule // testbench
`default_nettype wire
